// ---- verif/rsl_master_model.sv ----
`timescale 1ns/1ps
// ********
// Line master
// ********
module rsl_master_model (
	input wire logic pclk,
	input wire logic presetn,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	output logic tx_ready,
	input wire logic driver_enable
);
	logic [7:0] got[$];
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		tx_ready = 1'b0;
	end
	// Take reply bytes, stalling at random
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_byte);
		tx_ready <= presetn && ($urandom_range(3) != 0);
	end
	task automatic send(input logic [7:0] fr[$]);
		while (driver_enable)
			@(posedge pclk);
		repeat (8) @(posedge pclk);
		foreach (fr[i]) begin
			rx_valid <= 1'b1;
			rx_byte <= fr[i];
			@(posedge pclk);
			rx_valid <= 1'b0;
			rx_byte <= ~fr[i];
			repeat (7) @(posedge pclk);
		end
		repeat (40) @(posedge pclk);
	endtask
endmodule // rsl_master_model

// ---- verif/rsl_slave_monitor.sv ----
`timescale 1ns/1ps
// ********
// Checker
// ********
module rsl_slave_monitor
	import rsl_pkg::*;
#(
	parameter int HALF_CHAR_CYC = HALF_CHAR_CYC_DEF,
	parameter int MS_CYC = CYC_PER_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_valid,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_ready,
	input wire logic task_tick,
	input wire logic driver_enable
);
	localparam int TICK_MAX = 100 * MS_CYC;
	localparam int GAP_MIN = 7 * HALF_CHAR_CYC;
	logic [31:0] tick_cnt_q;
	logic [31:0] idle_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h0;
		end else if (task_tick) begin
			tick_cnt_q <= 32'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q <= 32'h0;
		end else if (rx_valid) begin
			idle_q <= 32'h0;
		end else if (idle_q != 32'hffffffff) begin
			idle_q <= idle_q + 32'h1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_stalled;
		tx_valid && !tx_ready;
	endsequence
	a_ready_wait: assert property (s_access |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	a_err_in_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside answer");
	a_tx_hold: assert property (s_stalled |=> tx_valid && $stable(tx_byte))
		else $error("tx byte dropped");
	a_drive_on_tx: assert property (tx_valid |-> driver_enable)
		else $error("line not driven");
	a_tick_pulse: assert property (task_tick |=> !task_tick)
		else $error("tick too long");
	a_tick_bound: assert property (tick_cnt_q < TICK_MAX)
		else $error("tick missing");
	a_gap_first: assert property ($rose(tx_valid) |-> idle_q >= GAP_MIN)
		else $error("reply inside frame");
endmodule // rsl_slave_monitor

bind rsl_slave rsl_slave_monitor #(.HALF_CHAR_CYC(HALF_CHAR_CYC), .MS_CYC(MS_CYC))
	rsl_slave_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .tx_valid(tx_valid),
	.tx_byte(tx_byte), .tx_ready(tx_ready), .task_tick(task_tick),
	.driver_enable(driver_enable));

// ---- verif/rtu_slave_link_control_test.sv ----
`timescale 1ns/1ps
module rtu_slave_link_control_test
	import rsl_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, er;
	logic tx_valid, tx_ready, host_halted, task_tick, driver_enable;
	logic [7:0] paddr, rx_byte, tx_byte, st;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] txq[$];
	int fail_count, check_count, cyc, n0, n;
	rsl_slave #(.HALF_CHAR_CYC(4), .MS_CYC(10)) rsl_slave_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
		.host_halted(host_halted), .task_tick(task_tick), .driver_enable(driver_enable));
	rsl_master_model rsl_master_model_i (.pclk(pclk), .presetn(presetn), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
		.driver_enable(driver_enable));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			close_out();
		end
	end
	task close_out;
		$display("Mismatches %0d, checks %0d", fail_count, check_count);
		if (fail_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
	task automatic frame(input logic [7:0] a, input logic bad, input int exp_tx);
		logic [7:0] fr[$];
		logic [15:0] c;
		fr = {a, 8'h03, 8'($urandom), 8'($urandom)};
		c = crc16(fr) ^ {15'h0, bad};
		fr.push_back(c[7:0]);
		fr.push_back(c[15:8]);
		n0 = rsl_master_model_i.got.size();
		rsl_master_model_i.send(fr);
		for (int i = 0; i < 800 && (exp_tx == 0 || rsl_master_model_i.got.size() < n0 + exp_tx); i++)
			@(posedge pclk);
		check("reply count", rsl_master_model_i.got.size() - n0, exp_tx);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, host_halted} = 5'h00;
		{paddr, pwdata, cyc, fail_count, check_count} = '0;
		void'($urandom(32'h05f23caf));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ADDR_CFG0, 32'h0);
		check("cfg0", rd, {GAP_DEF_HALF, 6'h00, TASK_DEF_MS, 1'b0, STATION_DEF});
		apb(1'b0, ADDR_CFG1, 32'h0);
		check("delay", rd, {16'h0000, DELAY_DEF_MS});
		apb(1'b0, ADDR_DIAG, 32'h0);
		check("diag", rd, 32'h10);
		apb(1'b0, 8'h30, 32'h0);
		check("unmapped", er, 1'b1);
		apb(1'b1, ADDR_CFG0, {16'h0000, TASK_DEF_MS, 1'b0, STATION_DEF});
		apb(1'b0, ADDR_DIAG, 32'h0);
		check("code", rd[15:8], CODE_TIMEOUT_PARAM);
		check("setup fault", rd[1], 1'b1);
		st = 8'($urandom_range(255, 1));
		apb(1'b1, ADDR_CFG0, {GAP_DEF_HALF, 6'h00, TASK_MIN_MS, 1'b0, st});
		apb(1'b0, ADDR_DIAG, 32'h0);
		check("fault clear", {rd[15:8], rd[1:0]}, 32'h0);
		for (n = 0; task_tick !== 1'b1 && n < 2000; n++)
			@(posedge pclk);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (task_tick !== 1'b1 && n < 2000);
		check("tick period", n, TASK_MIN_MS * 10);
		apb(1'b1, ADDR_CFG1, 32'h2);
		repeat (16) begin
			txq.push_back(8'($urandom));
			apb(1'b1, ADDR_TXDATA, {24'h0, txq[$]});
		end
		apb(1'b0, ADDR_TXDATA, 32'h0);
		check("tx space", rd[0], 1'b0);
		frame(st, 1'b0, 16);
		foreach (txq[i]) check("reply", rsl_master_model_i.got[n0 + i], txq[i]);
		apb(1'b0, ADDR_RXDATA, 32'h0);
		check("rx byte", rd[8:0], {1'b1, st});
		apb(1'b1, ADDR_TXDATA, 32'h5a);
		frame(BCAST_ADDR, 1'b0, 0);
		frame(st, 1'b1, 0);
		frame((st == 8'h01) ? 8'h02 : 8'h01, 1'b0, 0);
		host_halted <= 1'b1;
		frame(st, 1'b0, 0);
		apb(1'b1, ADDR_CFG0, {1'b1, GAP_DEF_HALF[8:0], 6'h00, TASK_MIN_MS, 1'b0, st});
		apb(1'b0, ADDR_CFG0, 32'h0);
		check("cfg0 run", rd, {1'b1, GAP_DEF_HALF[8:0], 6'h00, TASK_MIN_MS, 1'b0, st});
		frame(st, 1'b0, 1);
		check("halted reply", rsl_master_model_i.got[n0], 32'h5a);
		host_halted <= 1'b0;
		apb(1'b0, ADDR_STAT0, 32'h0);
		check("answered", rd[15:0], 32'h3);
		apb(1'b0, ADDR_STAT1, 32'h0);
		check("illegal", rd[31:16], 32'h1);
		apb(1'b1, ADDR_CMD, 32'h4);
		apb(1'b0, ADDR_STAT1, 32'h0);
		check("cleared", rd, 32'h0);
		apb(1'b1, ADDR_TXDATA, 32'h5a);
		apb(1'b1, ADDR_CMD, 32'h1);
		apb(1'b0, ADDR_DIAG, 32'h0);
		check("stopped", rd[4:0], 32'h0c);
		frame(st, 1'b0, 0);
		apb(1'b1, ADDR_CMD, 32'h3);
		apb(1'b0, ADDR_DIAG, 32'h0);
		check("restarted", rd[4:0], 32'h10);
		frame(st, 1'b0, 1);
		check("late reply", rsl_master_model_i.got[n0], 32'h5a);
		close_out();
	end
endmodule // rtu_slave_link_control_test

// ---- verilog/rsl_fifo.sv ----
`timescale 1ns/1ps
module rsl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic wr;
	logic rd;
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];
	assign wr = in_valid && in_ready;
	assign rd = out_valid && out_ready;
	always_ff @(posedge clk) begin
		if (wr) begin
			mem_q[wp_q] <= in_data;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (wr) begin
				wp_q <= wp_q + 1'b1;
			end
			if (rd) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
		end
	end
endmodule // rsl_fifo

// ---- verilog/rsl_pkg.sv ----
package rsl_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CFG0 = 8'h00;
	localparam logic [7:0] ADDR_CFG1 = 8'h04;
	localparam logic [7:0] ADDR_CMD = 8'h08;
	localparam logic [7:0] ADDR_DIAG = 8'h0c;
	localparam logic [7:0] ADDR_STAT0 = 8'h10;
	localparam logic [7:0] ADDR_STAT1 = 8'h14;
	localparam logic [7:0] ADDR_STAT2 = 8'h18;
	localparam logic [7:0] ADDR_STAT3 = 8'h1c;
	localparam logic [7:0] ADDR_RXDATA = 8'h20;
	localparam logic [7:0] ADDR_TXDATA = 8'h24;
	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [7:0] STATION_DEF = 8'h01;
	localparam logic [7:0] STATION_MIN = 8'h01;
	localparam logic [6:0] TASK_DEF_MS = 7'h32;
	localparam logic [6:0] TASK_MIN_MS = 7'h14;
	localparam logic [6:0] TASK_MAX_MS = 7'h64;
	localparam logic [15:0] DELAY_DEF_MS = 16'h0000;
	localparam logic [9:0] GAP_DEF_HALF = 10'h007;
	localparam logic [9:0] GAP_MIN_HALF = 10'h007;
	localparam logic [9:0] GAP_MAX_HALF = 10'h0c8;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] CODE_OK = 8'h00;
	localparam logic [7:0] CODE_TIMEOUT_PARAM = 8'h09;
	localparam logic [7:0] CODE_TX_TIMEOUT = 8'h18;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 10000000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int HALF_CHAR_CYC_DEF = 573;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_WAIT, ST_SEND} rsl_state_e;
	typedef struct packed {
		logic slave_active_flag;
		logic slave_halted_flag;
		logic halted_by_user_flag;
		logic setup_fault_flag;
		logic module_fault_flag;
	} rsl_diag_s;
endpackage

// ---- verilog/rsl_slave.sv ----
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module rsl_slave
	import rsl_pkg::*;
#(
	parameter int HALF_CHAR_CYC = HALF_CHAR_CYC_DEF,
	parameter int MS_CYC = CYC_PER_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	output logic tx_valid,
	output logic [7:0] tx_byte,
	input wire logic tx_ready,
	input wire logic host_halted,
	output logic task_tick,
	output logic driver_enable
);
	// ****************************************
	// Input sync and bus
	// ****************************************
	logic [1:0] halt_sync_q;
	logic acc;
	logic wr_acc;
	logic hit;
	logic [31:0] rd_d;
	logic [7:0] station_q;
	logic [6:0] task_ms_q;
	logic [15:0] delay_ms_q;
	logic [9:0] gap_half_q;
	logic run_halted_q;
	logic [7:0] fault_cause_code_q;
	rsl_diag_s diag_q;
	logic [15:0] stat_q [8];
	logic [7:0] inc;
	rsl_state_e state_q;
	logic [17:0] gap_cnt_q;
	logic [15:0] crc_q;
	logic [7:0] frm_addr_q;
	logic frm_first_q;
	logic [7:0] frm_len_q;
	logic [16:0] ms_cnt_q;
	logic [15:0] ms_left_q;
	logic [6:0] task_cnt_q;
	logic task_tick_q;
	logic rxf_out_valid;
	logic [7:0] rxf_out;
	logic rxf_pop;
	logic txf_in_ready;
	logic txf_valid;
	logic [7:0] txf_data;
	logic tx_valid_q;
	logic [7:0] tx_byte_q;
	logic serving;
	logic silence;
	logic frame_end;
	logic mine;
	logic ms_tick;
	logic [15:0] crc_n;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_sync_q <= 2'b00;
		end else begin
			halt_sync_q <= {halt_sync_q[0], host_halted};
		end
	end
	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	assign serving = diag_q.slave_active_flag && (!halt_sync_q[1] || run_halted_q);
	always_comb begin
		hit = 1'b1;
		rd_d = 32'h0000_0000;
		if (paddr == ADDR_CFG0) begin
			rd_d = {gap_half_q[9] | run_halted_q, gap_half_q[8:0], 6'h00, task_ms_q, 1'b0, station_q};
		end else if (paddr == ADDR_CFG1) begin
			rd_d = {16'h0000, delay_ms_q};
		end else if (paddr == ADDR_CMD) begin
			rd_d = 32'h0000_0000;
		end else if (paddr == ADDR_DIAG) begin
			rd_d = {16'h0000, fault_cause_code_q, 3'h0, diag_q};
		end else if (paddr == ADDR_STAT0) begin
			rd_d = {stat_q[1], stat_q[0]};
		end else if (paddr == ADDR_STAT1) begin
			rd_d = {stat_q[3], stat_q[2]};
		end else if (paddr == ADDR_STAT2) begin
			rd_d = {stat_q[5], stat_q[4]};
		end else if (paddr == ADDR_STAT3) begin
			rd_d = {stat_q[7], stat_q[6]};
		end else if (paddr == ADDR_RXDATA) begin
			rd_d = {23'h000000, rxf_out_valid, rxf_out};
		end else if (paddr == ADDR_TXDATA) begin
			rd_d = {31'h00000000, txf_in_ready};
		end else begin
			hit = 1'b0;
		end
	end
	assign rxf_pop = acc && !pwrite && !pready && paddr == ADDR_RXDATA && hit;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit;
			if (psel && penable && !pready) begin
				prdata <= rd_d;
			end
		end
	end
	// ****************************************
	// Configuration
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_q <= STATION_DEF;
			task_ms_q <= TASK_DEF_MS;
			delay_ms_q <= DELAY_DEF_MS;
			gap_half_q <= GAP_DEF_HALF;
			run_halted_q <= 1'b0;
		end else if (wr_acc && pready) begin
			if (paddr == ADDR_CFG0) begin
				if (pwdata[7:0] >= STATION_MIN) begin
					station_q <= pwdata[7:0];
				end
				if (pwdata[15:9] >= TASK_MIN_MS && pwdata[15:9] <= TASK_MAX_MS) begin
					task_ms_q <= pwdata[15:9];
				end
				if (pwdata[31:22] == 10'h000) begin
					gap_half_q <= pwdata[31:22];
				end else if (pwdata[31:22] >= GAP_MIN_HALF && pwdata[31:22] <= GAP_MAX_HALF) begin
					gap_half_q <= pwdata[31:22];
				end
				run_halted_q <= pwdata[31];
			end else if (paddr == ADDR_CFG1) begin
				delay_ms_q <= pwdata[15:0];
			end
		end
	end
	// ****************************************
	// Run state and faults
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_q <= '{slave_active_flag: 1'b1, default: 1'b0};
		end else begin
			if (wr_acc && pready && paddr == ADDR_CMD && pwdata[1]) begin
				diag_q.slave_active_flag <= 1'b1;
				diag_q.slave_halted_flag <= 1'b0;
				diag_q.halted_by_user_flag <= 1'b0;
			end else if (wr_acc && pready && paddr == ADDR_CMD && pwdata[0]) begin
				diag_q.slave_active_flag <= 1'b0;
				diag_q.slave_halted_flag <= 1'b1;
				diag_q.halted_by_user_flag <= 1'b1;
			end
			diag_q.setup_fault_flag <= (fault_cause_code_q != CODE_OK) &&
				(fault_cause_code_q != CODE_TX_TIMEOUT);
			diag_q.module_fault_flag <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_cause_code_q <= CODE_OK;
		end else if (gap_half_q == 10'h000) begin
			fault_cause_code_q <= CODE_TIMEOUT_PARAM;
		end else if (state_q == ST_SEND && txf_valid && !tx_ready && (&gap_cnt_q)) begin
			fault_cause_code_q <= CODE_TX_TIMEOUT;
		end else if (state_q == ST_IDLE && fault_cause_code_q == CODE_TIMEOUT_PARAM) begin
			fault_cause_code_q <= CODE_OK;
		end
	end
	// ****************************************
	// Timers
	// ****************************************
	assign ms_tick = (ms_cnt_q == 17'(MS_CYC - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_q <= '0;
			task_cnt_q <= '0;
			task_tick_q <= 1'b0;
		end else begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
			task_tick_q <= 1'b0;
			if (ms_tick) begin
				if (task_cnt_q + 1'b1 >= task_ms_q) begin
					task_cnt_q <= '0;
					task_tick_q <= 1'b1;
				end else begin
					task_cnt_q <= task_cnt_q + 1'b1;
				end
			end
		end
	end
	// ****************************************
	// Framing
	// ****************************************
	assign silence = ({14'h0000, gap_cnt_q} >= 32'(gap_half_q) * 32'(HALF_CHAR_CYC));
	assign frame_end = state_q == ST_RECV && silence;
	assign mine = frm_addr_q == station_q || frm_addr_q == BCAST_ADDR;
	always_comb begin
		crc_n = crc_q ^ {8'h00, rx_byte};
		for (int i = 0; i < 8; i++) begin
			crc_n = crc_n[0] ? (crc_n >> 1) ^ CRC_POLY : crc_n >> 1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			gap_cnt_q <= '0;
			crc_q <= CRC_INIT;
			frm_addr_q <= 8'h00;
			frm_first_q <= 1'b1;
			frm_len_q <= 8'h00;
			ms_left_q <= '0;
		end else begin
			gap_cnt_q <= (rx_valid || state_q == ST_IDLE) ? '0 :
				((&gap_cnt_q) ? gap_cnt_q : gap_cnt_q + 1'b1);
			case (state_q)
			ST_IDLE: begin
				if (rx_valid && serving) begin
					state_q <= ST_RECV;
					crc_q <= crc_n;
					frm_addr_q <= rx_byte;
					frm_len_q <= 8'h01;
				end
			end
			ST_RECV: begin
				if (rx_valid) begin
					crc_q <= crc_n;
					frm_len_q <= frm_len_q + 1'b1;
				end else if (frame_end) begin
					crc_q <= CRC_INIT;
					if (mine && crc_q == CRC_RESIDUE && frm_addr_q != BCAST_ADDR) begin
						state_q <= ST_WAIT;
						ms_left_q <= delay_ms_q;
					end else begin
						state_q <= ST_IDLE;
					end
				end
			end
			ST_WAIT: begin
				if (ms_left_q == 16'h0000) begin
					state_q <= ST_SEND;
				end else if (ms_tick) begin
					ms_left_q <= ms_left_q - 1'b1;
				end
			end
			ST_SEND: begin
				if (!txf_valid) begin
					state_q <= ST_IDLE;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end
	// ****************************************
	// Statistics
	// ****************************************
	always_comb begin
		inc = 8'h00;
		inc[2] = frame_end; // Frames seen
		inc[3] = frame_end && mine && crc_q != CRC_RESIDUE;
		inc[0] = frame_end && mine && crc_q == CRC_RESIDUE;
		inc[6] = state_q == ST_SEND && txf_valid && !tx_ready && (&gap_cnt_q);
	end
	generate
		for (genvar g = 0; g < 8; g++) begin : g_stat
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stat_q[g] <= 16'h0000;
				end else if (inc[g]) begin
					stat_q[g] <= stat_q[g] + 1'b1;
				end else if (wr_acc && pready && paddr == ADDR_CMD && pwdata[2]) begin
					stat_q[g] <= 16'h0000;
				end
			end
		end
	endgenerate
	// ****************************************
	// Data path
	// ****************************************
	rsl_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_rxf (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(rx_valid && serving && mine),
		.in_ready(),
		.in_data(rx_byte),
		.out_valid(rxf_out_valid),
		.out_ready(rxf_pop),
		.out_data(rxf_out)
	);
	rsl_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_txf (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(wr_acc && pready && paddr == ADDR_TXDATA),
		.in_ready(txf_in_ready),
		.in_data(pwdata[7:0]),
		.out_valid(txf_valid),
		.out_ready(state_q == ST_SEND && (!tx_valid_q || tx_ready)),
		.out_data(txf_data)
	);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid_q <= 1'b0;
			tx_byte_q <= 8'h00;
			driver_enable <= 1'b0;
		end else begin
			if (state_q == ST_SEND && txf_valid && (!tx_valid_q || tx_ready)) begin
				tx_valid_q <= 1'b1;
				tx_byte_q <= txf_data;
			end else if (tx_ready) begin
				tx_valid_q <= 1'b0;
			end
			driver_enable <= state_q == ST_SEND || tx_valid_q;
		end
	end
	assign tx_valid = tx_valid_q;
	assign tx_byte = tx_byte_q;
	assign task_tick = task_tick_q;
endmodule // rsl_slave
